// ### shared/irqc_consts.svh
`ifndef IRQC_CONSTS_SVH
`define IRQC_CONSTS_SVH

// register byte addresses
`define TIMER_CTRL_ADDR     32'h0000_0088
`define SERIAL_FLAGS_ADDR   32'h0000_0098
`define IRQ_ENABLE_ADDR     32'h0000_00A8
`define PRIORITY_ADDR       32'h0000_00B8
`define TIMER_TWO_CTRL_ADDR 32'h0000_00C8
`define STATUS_ADDR         32'h0000_00D0

// enable register fields
`define GLOBAL_EN_BIT       7
`define RESERVED_IE_BIT     6
`define SRC_BITS            6

// timer control fields
`define EXT0_SENSE_BIT      0
`define EXT0_FLAG_BIT       1
`define EXT1_SENSE_BIT      2
`define EXT1_FLAG_BIT       3
`define TF0_BIT             5
`define TF1_BIT             7

// serial flags fields
`define RX_DONE_BIT         0
`define TX_DONE_BIT         1

// timer two control fields
`define TF2_BIT             7
`define TIMER_TWO_EXTERNAL_FLAG_BIT            6
`define BAUD_MODE_BIT       4
`define EXT_ENABLE_BIT      3

// status fields
`define ST_REQ_BIT          0
`define ST_LO_BIT           1
`define ST_HI_BIT           2
`define ST_SRC_LSB          4
`define ST_WD_BIT           7

// reset values
`define IE_RESET            8'h00
`define PRIO_RESET          8'h00
`define CTRL_RESET          8'h00

// vectors
`define VEC_RESET           16'h0000
`define VEC_EXT0            16'h0003
`define VEC_T0              16'h000B
`define VEC_EXT1            16'h0013
`define VEC_T1              16'h001B
`define VEC_SERIAL          16'h0023
`define VEC_T2              16'h002B
`define ERASED_BYTE         8'hFF

`endif

// ### shared/irqc_pkg.sv
`default_nettype none
package irqc_pkg;
	typedef enum logic [2:0] {
		SRC_EXT0   = 3'h0,
		SRC_T0     = 3'h1,
		SRC_EXT1   = 3'h2,
		SRC_T1     = 3'h3,
		SRC_SERIAL = 3'h4,
		SRC_T2     = 3'h5
	} src_t;
	typedef logic [7:0] reg8_t;
endpackage
`default_nettype wire

// ### src/irq_controller.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irqc_consts.svh"

// Summary of operation
// - global enable bit 7 clear blocks every request; set lets source bits gate
// - source enables: bit5 timer two, 4 serial, 3 timer one, 2 ext1, 1 timer0, 0 ext0
// - vectors 0000h reset, 0003h, 000Bh, 0013h, 001Bh, 0023h, 002Bh
// - erased first program byte sends boot to in-system programming routine
// - sense bit one: falling edge on external pin raises request
// - sense bit zero: low level on external pin raises request
// - external request flags live in timer control register
// - edge-sensed external flag clears when service begins
// - level-sensed external flag stays on service; software clears it
// - timer zero and one rollovers request; not timer zero in mode 3
// - timer zero and one flags clear when service begins
// - timer two requests on overflow or external flag, one shared vector
// - timer two overflow flag on rollover, external flag on falling pin
// - timer two flags survive service; software finds and clears them
// - software may set or clear every flag, same effect as hardware
// - baud mode rollover sets no timer two overflow flag
// - baud mode external edge sets flag without reload
// - eight sources plus watchdog on seven vectors
// - same level order: ext0, timer0, ext1, timer1, serial, timer two
// - priority bit one beats every source with priority bit zero
// - enable register resets to zero
// - serial done flags survive service; software clears them
module irq_controller #(
	parameter int unsigned VECTOR_W   = 16,
	parameter logic [15:0] ISP_VECTOR = 16'hF000
) (
	input  wire logic                CLK,
	input  wire logic                SRST,
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output var  logic [31:0]         HRDATA,
	output var  logic                HREADYOUT,
	output var  logic                HRESP,
	input  wire logic                EXT_REQUEST_PIN_ZERO_N,
	input  wire logic                EXT_REQUEST_PIN_ONE_N,
	input  wire logic                TIMER_TWO_EXTERNAL_PIN,
	input  wire logic                TIMER_ZERO_ROLLOVER,
	input  wire logic                TIMER_ZERO_MODE3,
	input  wire logic                TIMER_ONE_ROLLOVER,
	input  wire logic                TIMER_TWO_ROLLOVER,
	input  wire logic                SERIAL_RX_DONE,
	input  wire logic                SERIAL_TX_DONE,
	input  wire logic                WATCHDOG_RESET_CAUSE,
	input  wire logic [7:0]          BOOT_BYTE,
	input  wire logic                IRQ_ACK,
	input  wire logic                IRQ_RETURN,
	output var  logic                IRQ_REQ,
	output var  logic [VECTOR_W-1:0] IRQ_VECTOR,
	output var  logic [VECTOR_W-1:0] BOOT_VECTOR,
	output var  logic                TIMER_TWO_RELOAD
);

	if (VECTOR_W < 16)
	begin : g_chk
		$error("VECTOR_W must be at least 16");
	end

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [15:0] vec_of(input irqc_pkg::src_t s);
		unique case (s)
			irqc_pkg::SRC_EXT0:   vec_of = `VEC_EXT0;
			irqc_pkg::SRC_T0:     vec_of = `VEC_T0;
			irqc_pkg::SRC_EXT1:   vec_of = `VEC_EXT1;
			irqc_pkg::SRC_T1:     vec_of = `VEC_T1;
			irqc_pkg::SRC_SERIAL: vec_of = `VEC_SERIAL;
			irqc_pkg::SRC_T2:     vec_of = `VEC_T2;
			default:              vec_of = `VEC_RESET;
		endcase
	endfunction

	// lowest index wins within one level
	function automatic irqc_pkg::src_t pick(input logic [5:0] m);
		pick = irqc_pkg::SRC_EXT0;
		for (int i = 5; i >= 0; i--)
		begin
			if (m[i])
			begin
				pick = irqc_pkg::src_t'(3'(i));
			end
		end
	endfunction

	// bus state
	logic        rd_pend_q, rd_pend_d;
	logic        wr_pend_q, wr_pend_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic        hready_q, hready_d;
	logic        hresp_q;

	// control registers
	irqc_pkg::reg8_t ie_q, ie_d;
	irqc_pkg::reg8_t ip_q, ip_d;
	logic            sense0_q, sense0_d;
	logic            sense1_q, sense1_d;
	logic            baud_q, baud_d;
	logic            timer_two_external_enable_q, timer_two_external_enable_d;

	// request flags
	logic ext0_q, ext0_d;
	logic ext1_q, ext1_d;
	logic tf0_q, tf0_d;
	logic tf1_q, tf1_d;
	logic tf2_q, tf2_d;
	logic timer_two_external_flag_q, timer_two_external_flag_d;
	logic ri_q, ri_d;
	logic ti_q, ti_d;

	// pin history and arbitration state
	logic            pin0_q, pin1_q, pin2_q;
	logic            insvc_hi_q, insvc_hi_d;
	logic            insvc_lo_q, insvc_lo_d;
	logic            req_q, req_d;
	logic            lvl_q, lvl_d;
	irqc_pkg::src_t  src_q, src_d;
	logic [VECTOR_W-1:0] vec_q, vec_d;
	logic            reload_q, reload_d;
	logic            started_q;
	logic            wd_q;
	logic [VECTOR_W-1:0] boot_q;

	logic       wr, acked, fall0, fall1, fall2;
	logic [7:0] w;
	logic [5:0] pend, hi_m, lo_m;

	always_comb
	begin
		wr    = wr_pend_q;
		w     = HWDATA[7:0];
		acked = IRQ_ACK && req_q;
		fall0 = pin0_q && !EXT_REQUEST_PIN_ZERO_N;
		fall1 = pin1_q && !EXT_REQUEST_PIN_ONE_N;
		fall2 = pin2_q && !TIMER_TWO_EXTERNAL_PIN;
	end

	// bus slave: writes have no wait state, reads one
	always_comb
	begin
		rd_pend_d = 1'b0;
		wr_pend_d = 1'b0;
		addr_d    = addr_q;
		hrdata_d  = hrdata_q;
		hready_d  = 1'b1;
		if (rd_pend_q)
		begin
			hrdata_d = 32'h0000_0000;
			if (hit(addr_q, `TIMER_CTRL_ADDR))
			begin
				hrdata_d[`EXT0_SENSE_BIT] = sense0_q;
				hrdata_d[`EXT0_FLAG_BIT]  = ext0_q;
				hrdata_d[`EXT1_SENSE_BIT] = sense1_q;
				hrdata_d[`EXT1_FLAG_BIT]  = ext1_q;
				hrdata_d[`TF0_BIT]        = tf0_q;
				hrdata_d[`TF1_BIT]        = tf1_q;
			end
			if (hit(addr_q, `SERIAL_FLAGS_ADDR))
			begin
				hrdata_d[`RX_DONE_BIT] = ri_q;
				hrdata_d[`TX_DONE_BIT] = ti_q;
			end
			if (hit(addr_q, `IRQ_ENABLE_ADDR))
			begin
				hrdata_d[7:0] = ie_q;
			end
			if (hit(addr_q, `PRIORITY_ADDR))
			begin
				hrdata_d[7:0] = ip_q;
			end
			if (hit(addr_q, `TIMER_TWO_CTRL_ADDR))
			begin
				hrdata_d[`TF2_BIT]        = tf2_q;
				hrdata_d[`TIMER_TWO_EXTERNAL_FLAG_BIT]       = timer_two_external_flag_q;
				hrdata_d[`BAUD_MODE_BIT]  = baud_q;
				hrdata_d[`EXT_ENABLE_BIT] = timer_two_external_enable_q;
			end
			if (hit(addr_q, `STATUS_ADDR))
			begin
				hrdata_d[`ST_REQ_BIT] = req_q;
				hrdata_d[`ST_LO_BIT]  = insvc_lo_q;
				hrdata_d[`ST_HI_BIT]  = insvc_hi_q;
				hrdata_d[`ST_SRC_LSB +: 3] = src_q;
				hrdata_d[`ST_WD_BIT]  = wd_q;
			end
		end
		else if (HSEL && HREADY && HTRANS[1])
		begin
			addr_d    = HADDR;
			rd_pend_d = !HWRITE;
			wr_pend_d = HWRITE;
			hready_d  = HWRITE;
		end
	end

	// control registers and flags; a hardware set beats a same-cycle clear
	always_comb
	begin
		ie_d     = ie_q;
		ip_d     = ip_q;
		sense0_d = sense0_q;
		sense1_d = sense1_q;
		baud_d   = baud_q;
		timer_two_external_enable_d  = timer_two_external_enable_q;
		ext0_d   = ext0_q;
		ext1_d   = ext1_q;
		tf0_d    = tf0_q;
		tf1_d    = tf1_q;
		tf2_d    = tf2_q;
		timer_two_external_flag_d   = timer_two_external_flag_q;
		ri_d     = ri_q;
		ti_d     = ti_q;
		if (wr && hit(addr_q, `IRQ_ENABLE_ADDR))
		begin
			ie_d = w;
			ie_d[`RESERVED_IE_BIT] = 1'b0;
		end
		if (wr && hit(addr_q, `PRIORITY_ADDR))
		begin
			ip_d = {2'b00, w[`SRC_BITS-1:0]};
		end
		if (wr && hit(addr_q, `TIMER_CTRL_ADDR))
		begin
			sense0_d = w[`EXT0_SENSE_BIT];
			sense1_d = w[`EXT1_SENSE_BIT];
			ext0_d   = w[`EXT0_FLAG_BIT];
			ext1_d   = w[`EXT1_FLAG_BIT];
			tf0_d    = w[`TF0_BIT];
			tf1_d    = w[`TF1_BIT];
		end
		if (wr && hit(addr_q, `SERIAL_FLAGS_ADDR))
		begin
			ri_d = w[`RX_DONE_BIT];
			ti_d = w[`TX_DONE_BIT];
		end
		if (wr && hit(addr_q, `TIMER_TWO_CTRL_ADDR))
		begin
			tf2_d   = w[`TF2_BIT];
			timer_two_external_flag_d  = w[`TIMER_TWO_EXTERNAL_FLAG_BIT];
			baud_d  = w[`BAUD_MODE_BIT];
			timer_two_external_enable_d = w[`EXT_ENABLE_BIT];
		end
		if (acked)
		begin
			unique case (src_q)
				irqc_pkg::SRC_EXT0:
				begin
					if (sense0_q)
					begin
						ext0_d = 1'b0;
					end
				end
				irqc_pkg::SRC_EXT1:
				begin
					if (sense1_q)
					begin
						ext1_d = 1'b0;
					end
				end
				irqc_pkg::SRC_T0:     tf0_d = 1'b0;
				irqc_pkg::SRC_T1:     tf1_d = 1'b0;
				irqc_pkg::SRC_SERIAL: ri_d  = ri_d;
				irqc_pkg::SRC_T2:     tf2_d = tf2_d;
				default:              tf2_d = tf2_d;
			endcase
		end
		if (sense0_q ? fall0 : !EXT_REQUEST_PIN_ZERO_N)
		begin
			ext0_d = 1'b1;
		end
		if (sense1_q ? fall1 : !EXT_REQUEST_PIN_ONE_N)
		begin
			ext1_d = 1'b1;
		end
		if (TIMER_ZERO_ROLLOVER && !TIMER_ZERO_MODE3)
		begin
			tf0_d = 1'b1;
		end
		if (TIMER_ONE_ROLLOVER)
		begin
			tf1_d = 1'b1;
		end
		if (TIMER_TWO_ROLLOVER && !baud_q)
		begin
			tf2_d = 1'b1;
		end
		if (fall2 && timer_two_external_enable_q)
		begin
			timer_two_external_flag_d = 1'b1;
		end
		if (SERIAL_RX_DONE)
		begin
			ri_d = 1'b1;
		end
		if (SERIAL_TX_DONE)
		begin
			ti_d = 1'b1;
		end
		reload_d = fall2 && timer_two_external_enable_q && !baud_q;
	end

	// arbitration and nesting
	always_comb
	begin
		pend = {tf2_q || timer_two_external_flag_q, ri_q || ti_q, tf1_q, ext1_q, tf0_q, ext0_q};
		pend = pend & ie_q[`SRC_BITS-1:0];
		pend = pend & {`SRC_BITS{ie_q[`GLOBAL_EN_BIT]}};
		hi_m = pend & ip_q[`SRC_BITS-1:0];
		lo_m = pend & ~ip_q[`SRC_BITS-1:0];
		insvc_hi_d = insvc_hi_q;
		insvc_lo_d = insvc_lo_q;
		if (IRQ_RETURN)
		begin
			if (insvc_hi_q)
			begin
				insvc_hi_d = 1'b0;
			end
			else
			begin
				insvc_lo_d = 1'b0;
			end
		end
		if (acked)
		begin
			if (lvl_q)
			begin
				insvc_hi_d = 1'b1;
			end
			else
			begin
				insvc_lo_d = 1'b1;
			end
		end
		req_d = 1'b0;
		lvl_d = lvl_q;
		src_d = src_q;
		if (|hi_m && !insvc_hi_q)
		begin
			req_d = !acked;
			lvl_d = 1'b1;
			src_d = pick(hi_m);
		end
		else if (|lo_m && !insvc_hi_q && !insvc_lo_q)
		begin
			req_d = !acked;
			lvl_d = 1'b0;
			src_d = pick(lo_m);
		end
		vec_d = VECTOR_W'(vec_of(src_d));
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			rd_pend_q  <= 1'b0;
			wr_pend_q  <= 1'b0;
			addr_q     <= 32'h0000_0000;
			hrdata_q   <= 32'h0000_0000;
			hready_q   <= 1'b1;
			hresp_q    <= 1'b0;
			ie_q       <= `IE_RESET;
			ip_q       <= `PRIO_RESET;
			sense0_q   <= 1'b0;
			sense1_q   <= 1'b0;
			baud_q     <= 1'b0;
			timer_two_external_enable_q    <= 1'b0;
			ext0_q     <= 1'b0;
			ext1_q     <= 1'b0;
			tf0_q      <= 1'b0;
			tf1_q      <= 1'b0;
			tf2_q      <= 1'b0;
			timer_two_external_flag_q     <= 1'b0;
			ri_q       <= 1'b0;
			ti_q       <= 1'b0;
			pin0_q     <= 1'b1;
			pin1_q     <= 1'b1;
			pin2_q     <= 1'b1;
			insvc_hi_q <= 1'b0;
			insvc_lo_q <= 1'b0;
			req_q      <= 1'b0;
			lvl_q      <= 1'b0;
			src_q      <= irqc_pkg::SRC_EXT0;
			vec_q      <= VECTOR_W'(`VEC_RESET);
			reload_q   <= 1'b0;
			started_q  <= 1'b0;
			wd_q       <= 1'b0;
			boot_q     <= VECTOR_W'(`VEC_RESET);
		end
		else
		begin
			rd_pend_q  <= rd_pend_d;
			wr_pend_q  <= wr_pend_d;
			addr_q     <= addr_d;
			hrdata_q   <= hrdata_d;
			hready_q   <= hready_d;
			ie_q       <= ie_d;
			ip_q       <= ip_d;
			sense0_q   <= sense0_d;
			sense1_q   <= sense1_d;
			baud_q     <= baud_d;
			timer_two_external_enable_q    <= timer_two_external_enable_d;
			ext0_q     <= ext0_d;
			ext1_q     <= ext1_d;
			tf0_q      <= tf0_d;
			tf1_q      <= tf1_d;
			tf2_q      <= tf2_d;
			timer_two_external_flag_q     <= timer_two_external_flag_d;
			ri_q       <= ri_d;
			ti_q       <= ti_d;
			pin0_q     <= EXT_REQUEST_PIN_ZERO_N;
			pin1_q     <= EXT_REQUEST_PIN_ONE_N;
			pin2_q     <= TIMER_TWO_EXTERNAL_PIN;
			insvc_hi_q <= insvc_hi_d;
			insvc_lo_q <= insvc_lo_d;
			req_q      <= req_d;
			lvl_q      <= lvl_d;
			src_q      <= src_d;
			vec_q      <= vec_d;
			reload_q   <= reload_d;
			started_q  <= 1'b1;
			if (!started_q)
			begin
				wd_q <= WATCHDOG_RESET_CAUSE;
				boot_q <= (BOOT_BYTE == `ERASED_BYTE) ? VECTOR_W'(ISP_VECTOR)
					: VECTOR_W'(`VEC_RESET);
			end
		end
	end

	assign HRDATA           = hrdata_q;
	assign HREADYOUT        = hready_q;
	assign HRESP            = hresp_q;
	assign IRQ_REQ          = req_q;
	assign IRQ_VECTOR       = vec_q;
	assign BOOT_VECTOR      = boot_q;
	assign TIMER_TWO_RELOAD = reload_q;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	global_gate_a: assert property (!ie_q[7] |=> !IRQ_REQ)
		else $error("request raised with global enable off");
	source_gate_a: assert property (IRQ_REQ |-> $past(ie_q[src_d]))
		else $error("request from a disabled source");
	boot_vector_a: assert property ($rose(started_q) |->
		BOOT_VECTOR == (($past(BOOT_BYTE) == 8'hFF) ? ISP_VECTOR : 16'h0000))
		else $error("boot vector wrong");
	edge_set_a: assert property (sense0_q && $past(EXT_REQUEST_PIN_ZERO_N)
		&& !EXT_REQUEST_PIN_ZERO_N |=> ext0_q)
		else $error("falling edge missed");
	level_set_a: assert property (!sense0_q && !EXT_REQUEST_PIN_ZERO_N |=> ext0_q)
		else $error("low level missed");
	edge_clear_a: assert property (acked && src_q == irqc_pkg::SRC_EXT0 && sense0_q
		&& !wr && !fall0 |=> !ext0_q)
		else $error("edge flag not cleared on service");
	level_keep_a: assert property (acked && src_q == irqc_pkg::SRC_EXT0 && !sense0_q
		&& ext0_q && !wr |=> ext0_q)
		else $error("level flag cleared on service");
	timer_clear_a: assert property (acked && src_q == irqc_pkg::SRC_T1 && !wr
		&& !TIMER_ONE_ROLLOVER |=> !tf1_q)
		else $error("timer one flag kept");
	t2_keep_a: assert property (acked && src_q == irqc_pkg::SRC_T2 && tf2_q && !wr
		|=> tf2_q)
		else $error("timer two flag cleared on service");
	baud_mask_a: assert property (baud_q && !tf2_q && !wr |=> !tf2_q)
		else $error("baud rollover set overflow flag");
	nest_block_a: assert property (insvc_hi_q && !IRQ_RETURN |=> !IRQ_REQ)
		else $error("request during high level service");
	high_first_a: assert property (IRQ_REQ && $past(|hi_m) && !$past(insvc_hi_q)
		|-> lvl_q)
		else $error("low level chosen over high");

	ack_c: cover property (IRQ_REQ && IRQ_ACK);
	nested_c: cover property (insvc_lo_q && insvc_hi_q);
	return_c: cover property (IRQ_RETURN ##1 IRQ_REQ);

endmodule
`default_nettype wire

// ### sim/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        IRQ_REQ,
	input  wire logic [15:0] IRQ_VECTOR,
	input  wire logic        ack_en,
	input  wire logic [3:0]  ack_delay,
	input  wire logic [3:0]  ret_delay,
	output var  logic        IRQ_ACK,
	output var  logic        IRQ_RETURN,
	output var  logic [15:0] taken_vec,
	output var  logic [7:0]  taken_cnt,
	output var  logic        idle
);
	logic [1:0] st_q;
	logic [3:0] wait_q;
	assign idle = (st_q == 2'h0);
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			IRQ_ACK    <= 1'b0;
			IRQ_RETURN <= 1'b0;
			taken_vec  <= 16'h0000;
			taken_cnt  <= 8'h00;
			st_q       <= 2'h0;
			wait_q     <= 4'h0;
		end
		else
		begin
			IRQ_ACK    <= 1'b0;
			IRQ_RETURN <= 1'b0;
			case (st_q)
			2'h0:
			begin
				wait_q <= (ack_en && IRQ_REQ) ? wait_q + 4'h1 : 4'h0;
				if (ack_en && IRQ_REQ && wait_q >= ack_delay)
				begin
					IRQ_ACK <= 1'b1;
					st_q    <= 2'h1;
				end
			end
			2'h1:
			begin
				taken_vec <= IRQ_VECTOR;
				taken_cnt <= taken_cnt + 8'h01;
				wait_q    <= 4'h0;
				st_q      <= 2'h2;
			end
			2'h2:
			begin
				wait_q <= wait_q + 4'h1;
				if (wait_q >= ret_delay)
				begin
					IRQ_RETURN <= 1'b1; // handler ends, its level opens again
					st_q       <= 2'h3;
				end
			end
			default:
			begin
				wait_q <= 4'h0;
				st_q   <= 2'h0;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irqc_consts.svh"
module tb;
	localparam logic [15:0] IN_SYSTEM_PROGRAMMING_ROUTINE = 16'h7E00; // arbitrary
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        pin0_n = 1'b1;
	logic        pin1_n = 1'b1;
	logic        timer_two_external_pin = 1'b1;
	logic        t0_roll = 1'b0;
	logic        t0_mode3 = 1'b0;
	logic        t1_roll = 1'b0;
	logic        t2_roll = 1'b0;
	logic        rx_done = 1'b0;
	logic        tx_done = 1'b0;
	logic        wd_cause = 1'b0;
	logic [7:0]  boot_byte = 8'hFF;
	logic        irq_ack;
	logic        irq_ret;
	logic        irq_req;
	logic        t2_reload;
	logic        reload_seen = 1'b0;
	logic [15:0] irq_vec;
	logic [15:0] boot_vec;
	logic [15:0] taken_vec;
	logic [7:0]  taken_cnt;
	logic        core_idle;
	logic        ack_en = 1'b0;
	logic [3:0]  ack_dly = 4'h0;
	logic [3:0]  ret_dly = 4'h2;
	logic [31:0] rd;
	logic [15:0] vec_tab [6] = '{`VEC_EXT0, `VEC_T0, `VEC_EXT1, `VEC_T1, `VEC_SERIAL, `VEC_T2};
	logic [7:0]  mask_tab [6] = '{8'h02, 8'h20, 8'h08, 8'h80, 8'h03, 8'h80};
	int          error_cnt = 0;
	int          total_checks = 0;

	irq_controller #(.ISP_VECTOR(IN_SYSTEM_PROGRAMMING_ROUTINE)) u_irq_controller (.CLK(clk), .SRST(srst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.EXT_REQUEST_PIN_ZERO_N(pin0_n), .EXT_REQUEST_PIN_ONE_N(pin1_n),
		.TIMER_TWO_EXTERNAL_PIN(timer_two_external_pin), .TIMER_ZERO_ROLLOVER(t0_roll), .TIMER_ZERO_MODE3(t0_mode3),
		.TIMER_ONE_ROLLOVER(t1_roll), .TIMER_TWO_ROLLOVER(t2_roll), .SERIAL_RX_DONE(rx_done),
		.SERIAL_TX_DONE(tx_done), .WATCHDOG_RESET_CAUSE(wd_cause), .BOOT_BYTE(boot_byte),
		.IRQ_ACK(irq_ack), .IRQ_RETURN(irq_ret), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vec),
		.BOOT_VECTOR(boot_vec), .TIMER_TWO_RELOAD(t2_reload));
	core_model u_core_model (.CLK(clk), .SRST(srst), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vec),
		.ack_en(ack_en), .ack_delay(ack_dly), .ret_delay(ret_dly), .IRQ_ACK(irq_ack),
		.IRQ_RETURN(irq_ret), .taken_vec(taken_vec), .taken_cnt(taken_cnt), .idle(core_idle));

	always #2.5 clk = ~clk;
	always @(posedge clk) if (t2_reload === 1'b1) reload_seen <= 1'b1;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		chk_reg({16'h0000, got}, {16'h0000, exp});
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 40);
		if (n >= 40)
			error_cnt++;
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wait_core(input logic [7:0] k0);
		int n;
		n = 0;
		while ((taken_cnt === k0 || core_idle !== 1'b1) && n < 90)
		begin
			@(posedge clk);
			if (taken_cnt !== k0)
				ack_en <= 1'b0;
			n++;
		end
		if (n >= 90)
			error_cnt++;
	endtask
	task automatic fall(input int i);
		if (i == 0)
			pin0_n <= 1'b0;
		else if (i == 2)
			pin1_n <= 1'b0;
		else
			timer_two_external_pin <= 1'b0;
		edges(12); // source holds each level
		pin0_n <= 1'b1;
		pin1_n <= 1'b1;
		timer_two_external_pin   <= 1'b1;
		edges(12);
	endtask
	task automatic trig(input int i);
		if (i == 0 || i == 2)
			fall(i);
		t0_roll <= (i == 1);
		t1_roll <= (i == 3);
		rx_done <= (i == 4);
		tx_done <= (i == 4);
		t2_roll <= (i == 5);
		edges(1);
		{t0_roll, t1_roll, rx_done, tx_done, t2_roll} <= 5'h00;
		edges(2);
	endtask
	function automatic int pick(input logic [5:0] pend, input logic [5:0] prio);
		for (int i = 0; i < 6; i++)
			if (((pend & prio) != 6'h00) ? pend[i] & prio[i] : pend[i])
				return i;
		return 6;
	endfunction
	function automatic logic [31:0] faddr(input int i);
		return (i == 4) ? `SERIAL_FLAGS_ADDR : (i == 5) ? `TIMER_TWO_CTRL_ADDR : `TIMER_CTRL_ADDR;
	endfunction

	initial
	begin
		#200000;
		error_cnt++;
		print_verdict();
	end

	initial
	begin
		logic [5:0] pend;
		logic [5:0] prio;
		int k;
		k = $urandom(85);
		edges(3);
		srst <= 1'b0;
		edges(3);
		chk_vec(boot_vec, IN_SYSTEM_PROGRAMMING_ROUTINE);
		bus(0, `IRQ_ENABLE_ADDR, 0);
		chk_reg(rd, 32'h0000_0000);
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_00FF);
		bus(0, `IRQ_ENABLE_ADDR, 0);
		chk_reg(rd, 32'h0000_00BF);
		bus(0, 32'h0000_0100, 0);
		chk_reg(rd, 32'h0000_0000);
		chk_bit(hresp, 1'b0);
		srst      <= 1'b1;
		boot_byte <= 8'($urandom) & 8'h7F;
		wd_cause  <= 1'b1;
		edges(2);
		srst <= 1'b0;
		edges(3);
		wd_cause <= 1'b0;
		chk_vec(boot_vec, 16'h0000);
		bus(0, `STATUS_ADDR, 0);
		chk_bit(rd[7], 1'b1);
		$display("test reset done");
		bus(1, `TIMER_CTRL_ADDR, 32'h0000_0005);
		for (int i = 0; i < 6; i++)
		begin
			bus(1, `IRQ_ENABLE_ADDR, 32'h0000_0080 | (32'h0000_0001 << i));
			ack_dly <= 4'($urandom_range(9));
			ack_en  <= 1'b1;
			k = taken_cnt;
			trig(i);
			wait_core(8'(k));
			chk_vec(taken_vec, vec_tab[i]);
			bus(0, faddr(i), 0);
			chk_reg(rd & mask_tab[i], (i >= 4) ? mask_tab[i] : 0);
			chk_bit(irq_req, i >= 4);
			bus(1, faddr(i), (i < 4) ? 32'h0000_0005 : 32'h0000_0000);
			edges(3);
			chk_bit(irq_req, 1'b0);
		end
		$display("test vectors done");
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_003F);
		trig(3);
		edges(2);
		chk_bit(irq_req, 1'b0);
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_0088);
		edges(3);
		chk_bit(irq_req, 1'b1);
		chk_vec(irq_vec, `VEC_T1);
		bus(1, `TIMER_CTRL_ADDR, 32'h0000_0005);
		edges(3);
		chk_bit(irq_req, 1'b0);
		t0_mode3 <= 1'b1;
		trig(1);
		t0_mode3 <= 1'b0;
		bus(0, `TIMER_CTRL_ADDR, 0);
		chk_reg(rd, 32'h0000_0005);
		$display("test gating done");
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_00BF);
		for (int r = 0; r < 12; r++)
		begin
			pend = (r == 0 || r == 11) ? 6'h3F : 6'($urandom_range(63, 1));
			prio = (r == 0) ? 6'h20 : (r == 11) ? 6'h00 : 6'($urandom);
			bus(1, `PRIORITY_ADDR, {26'h0, prio});
			bus(1, `TIMER_CTRL_ADDR, {24'h0, pend[3], 1'b0, pend[1], 1'b0, pend[2], 1'b1, pend[0], 1'b1});
			bus(1, `SERIAL_FLAGS_ADDR, {31'h0, pend[4]});
			bus(1, `TIMER_TWO_CTRL_ADDR, {24'h0, pend[5], 7'h0});
			edges(3);
			k = pick(pend, prio);
			chk_bit(irq_req, k < 6);
			chk_vec(irq_vec, vec_tab[k]);
		end
		ret_dly <= 4'hF;
		ack_en  <= 1'b1;
		k = taken_cnt;
		while (taken_cnt === 8'(k))
			edges(1);
		ack_en <= 1'b0;
		edges(3);
		chk_bit(irq_req, 1'b0);
		wait_core(8'(k));
		chk_vec(taken_vec, `VEC_EXT0);
		$display("test priority done");
		bus(1, `SERIAL_FLAGS_ADDR, 0);
		bus(1, `TIMER_TWO_CTRL_ADDR, 0);
		bus(1, `TIMER_CTRL_ADDR, 0);
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_0081);
		ret_dly <= 4'h2;
		ack_en  <= 1'b1;
		k = taken_cnt;
		pin0_n <= 1'b0;
		wait_core(8'(k));
		pin0_n <= 1'b1;
		chk_vec(taken_vec, `VEC_EXT0);
		bus(0, `TIMER_CTRL_ADDR, 0);
		chk_reg(rd, 32'h0000_0002);
		bus(1, `TIMER_CTRL_ADDR, 0);
		bus(0, `TIMER_CTRL_ADDR, 0);
		chk_reg(rd, 32'h0000_0000);
		$display("test level done");
		bus(1, `IRQ_ENABLE_ADDR, 32'h0000_00A0);
		bus(1, `TIMER_TWO_CTRL_ADDR, 32'h0000_0018);
		trig(5);
		chk_bit(irq_req, 1'b0);
		fall(5);
		bus(0, `TIMER_TWO_CTRL_ADDR, 0);
		chk_reg(rd, 32'h0000_0058);
		chk_bit(reload_seen, 1'b0);
		chk_bit(irq_req, 1'b1);
		bus(1, `TIMER_TWO_CTRL_ADDR, 32'h0000_0008);
		fall(5);
		trig(5);
		chk_bit(reload_seen, 1'b1);
		bus(0, `TIMER_TWO_CTRL_ADDR, 0);
		chk_reg(rd, 32'h0000_00C8);
		$display("test timer two done");
		print_verdict();
	end
endmodule
`default_nettype wire
